// File: rtl/cax_pkg.sv
// Constants for the charger auxiliary control register slice.
// Assumes an internal register port driven by the I2C front end on the same clock.
`default_nettype none
package cax_pkg;
	localparam logic [3:0] ADDR_PULSE_LINE = 4'hd;
	localparam logic [3:0] ADDR_DET_STATE = 4'he;
	localparam logic [3:0] ADDR_TRIM_IND = 4'hf;
	localparam logic [7:0] RST_PULSE_LINE = 8'h01;
	localparam logic [7:0] RST_TRIM_IND = 8'h00;
	localparam int POS_PULSE_EN = 7;
	localparam int POS_UP_REQ = 6;
	localparam int POS_DN_REQ = 5;
	localparam int POS_DPLUS = 3;
	localparam int POS_DMINUS = 1;
	localparam int POS_TEMP_EN = 0;
	localparam int POS_DET_DONE = 7;
	localparam int POS_TRIM = 6;
	localparam int POS_TRICKLE = 4;
	localparam int POS_IND = 2;
	localparam int POS_OFFSET = 0;
	localparam logic [1:0] MON_MODE_IND = 2'h1;
	localparam logic [1:0] IND_OFF = 2'h0;
	localparam logic [1:0] IND_LOW = 2'h1;
	localparam logic [1:0] IND_BLINK_1_1 = 2'h2;
	localparam int CLK_HZ = 10000000;
	localparam int BLINK_STEP_MS = 1000;
	localparam int BLINK_STEP_CYC = CLK_HZ / 1000 * BLINK_STEP_MS;
	typedef enum logic [1:0] {CAX_DRV_HIZ, CAX_DRV_0V, CAX_DRV_0V6, CAX_DRV_3V3} cax_drive_t;
endpackage
`default_nettype wire

// File: rtl/cax_if.sv
// Carrier between register core and indicator driver.
// Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
interface cax_ind_if;
	logic [1:0] pattern;
	logic active;
	logic led_low;
	modport core(output pattern, output active, input led_low);
	modport drv(input pattern, input active, output led_low);
endinterface
`default_nettype wire

// File: rtl/cax_indicator.sv
// Status indicator blink generator.
// Assumes a 10 MHz clock; one second ticks from a divider.
`timescale 1ns/1ns
`default_nettype none
module cax_indicator
	import cax_pkg::*;
#(
	parameter int STEP_CYC = BLINK_STEP_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Pattern
	cax_ind_if.drv ind
);
	logic [31:0] div_q;
	logic [1:0] sec_q;
	logic tick;
	assign tick = (div_q == 32'(STEP_CYC - 1));
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= '0;
		end else if (!ind.active || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 32'h1;
		end
	end
	// Phase restarts while the indicator is inactive, so each activation with a pattern other than IND_OFF begins with its on second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sec_q <= '0;
		end else if (!ind.active) begin
			sec_q <= '0;
		end else if (tick) begin
			sec_q <= sec_q + 2'h1;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ind.led_low <= 1'b0;
		end else if (!ind.active) begin
			ind.led_low <= 1'b0;
		end else begin
			case (ind.pattern)
				IND_OFF: ind.led_low <= 1'b0;
				IND_LOW: ind.led_low <= 1'b1;
				IND_BLINK_1_1: ind.led_low <= ~sec_q[0];
				default: ind.led_low <= (sec_q == 2'h0);
			endcase
		end
	end
endmodule
`default_nettype wire

// File: rtl/cax_regs.sv
// Register slice 0x0D..0x0F of the charger control map.
// Assumes the I2C front end presents one-cycle read/write strobes on clk.
`timescale 1ns/1ns
`default_nettype none
module cax_regs
	import cax_pkg::*;
#(
	parameter int STEP_CYC = BLINK_STEP_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port from I2C front end
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	// Reset sources
	input wire logic reg_reset_cmd,
	input wire logic watchdog_expired,
	output logic safety_timer_restart,
	// Charger events
	input wire logic source_plugged,
	input wire logic detection_done,
	input wire logic pulse_seq_done,
	input wire logic [1:0] charge_monitor_mode,
	// Control outputs
	output logic pulse_ctrl_enable,
	output logic pulse_voltage_up_req,
	output logic pulse_voltage_down_req,
	output cax_drive_t dplus_drive_sel,
	output cax_drive_t dminus_drive_sel,
	output logic temp_profile_enable,
	output logic [1:0] charge_voltage_trim,
	output logic trickle_current_sel,
	output logic [1:0] input_reg_offset_sel,
	output logic stat_led_low
);
	logic [7:0] pl_q;
	logic [7:0] ti_q;
	logic det_q;
	logic wr_pl;
	logic wr_ti;
	logic [7:0] rd_d;
	cax_ind_if ind();

	assign wr_pl = reg_wr && (reg_addr == ADDR_PULSE_LINE);
	assign wr_ti = reg_wr && (reg_addr == ADDR_TRIM_IND);
	// Writes to 0x0E simply fall through
	assign reg_hit = (reg_addr == ADDR_PULSE_LINE) || (reg_addr == ADDR_DET_STATE)
		|| (reg_addr == ADDR_TRIM_IND);
	assign safety_timer_restart = reg_reset_cmd;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			det_q <= 1'b0;
		end else if (reg_reset_cmd) begin
			det_q <= 1'b0;
		end else if (source_plugged) begin
			det_q <= 1'b0;
		end else if (detection_done) begin
			det_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pl_q <= RST_PULSE_LINE;
		end else if (reg_reset_cmd || watchdog_expired) begin
			pl_q <= RST_PULSE_LINE;
		end else begin
			if (wr_pl) begin
				pl_q[POS_PULSE_EN] <= reg_wdata[POS_PULSE_EN];
				pl_q[POS_TEMP_EN] <= reg_wdata[POS_TEMP_EN];
				// Requests gated by enable, held cleared otherwise
				pl_q[POS_UP_REQ] <= reg_wdata[POS_UP_REQ] & reg_wdata[POS_PULSE_EN]
					& pl_q[POS_PULSE_EN];
				pl_q[POS_DN_REQ] <= reg_wdata[POS_DN_REQ] & reg_wdata[POS_PULSE_EN]
					& pl_q[POS_PULSE_EN];
				if (det_q) begin
					pl_q[POS_DPLUS +: 2] <= reg_wdata[POS_DPLUS +: 2];
					pl_q[POS_DMINUS +: 2] <= reg_wdata[POS_DMINUS +: 2];
				end
			end else if (pulse_seq_done) begin
				pl_q[POS_UP_REQ] <= 1'b0;
				pl_q[POS_DN_REQ] <= 1'b0;
			end
			// Plug-in wins over a same-cycle write
			if (source_plugged) begin
				pl_q[POS_DPLUS +: 2] <= 2'h0;
				pl_q[POS_DMINUS +: 2] <= 2'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ti_q <= RST_TRIM_IND;
		end else if (reg_reset_cmd) begin
			ti_q <= RST_TRIM_IND;
		end else if (watchdog_expired) begin
			ti_q[7:2] <= RST_TRIM_IND[7:2];
		end else if (wr_ti) begin
			ti_q <= reg_wdata;
		end
	end

	always_comb begin
		case (reg_addr)
			ADDR_PULSE_LINE: rd_d = pl_q;
			ADDR_DET_STATE: rd_d = {det_q, 7'h00};
			ADDR_TRIM_IND: rd_d = ti_q;
			default: rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_d;
		end
	end

	assign pulse_ctrl_enable = pl_q[POS_PULSE_EN];
	assign pulse_voltage_up_req = pl_q[POS_UP_REQ];
	assign pulse_voltage_down_req = pl_q[POS_DN_REQ];
	assign dplus_drive_sel = cax_drive_t'(pl_q[POS_DPLUS +: 2]);
	assign dminus_drive_sel = cax_drive_t'(pl_q[POS_DMINUS +: 2]);
	assign temp_profile_enable = pl_q[POS_TEMP_EN];
	assign charge_voltage_trim = ti_q[POS_TRIM +: 2];
	assign trickle_current_sel = ti_q[POS_TRICKLE];
	assign input_reg_offset_sel = ti_q[POS_OFFSET +: 2];

	assign ind.pattern = ti_q[POS_IND +: 2];
	assign ind.active = (charge_monitor_mode == MON_MODE_IND);
	assign stat_led_low = ind.led_low;

	cax_indicator #(.STEP_CYC(STEP_CYC)) u_ind (
		.clk(clk),
		.nrst(nrst),
		.ind(ind)
	);
endmodule
`default_nettype wire

// File: test/cax_regs_asserts.sv
// Checker for the register slice.
// Bound to cax_regs; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module cax_regs_asserts
	import cax_pkg::*;
(
	// Clock and register port
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	// Events and outputs
	input wire logic reg_reset_cmd,
	input wire logic watchdog_expired,
	input wire logic safety_timer_restart,
	input wire logic source_plugged,
	input wire logic pulse_seq_done,
	input wire logic [1:0] charge_monitor_mode,
	input wire logic pulse_ctrl_enable,
	input wire logic pulse_voltage_up_req,
	input wire logic pulse_voltage_down_req,
	input wire logic [1:0] dplus_drive_sel,
	input wire logic [1:0] dminus_drive_sel,
	input wire logic [1:0] charge_voltage_trim,
	input wire logic trickle_current_sel,
	input wire logic [1:0] input_reg_offset_sel,
	input wire logic stat_led_low
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	reg_reset_a: assert property (reg_reset_cmd |=> !pulse_ctrl_enable
		&& input_reg_offset_sel == 2'h0) else $error("reg reset");
	timer_restart_a: assert property (safety_timer_restart == reg_reset_cmd)
		else $error("timer restart");
	wdog_keep_a: assert property (watchdog_expired && !reg_reset_cmd |=>
		input_reg_offset_sel == $past(input_reg_offset_sel) && !trickle_current_sel)
		else $error("watchdog");
	plug_clear_a: assert property (source_plugged |=> dplus_drive_sel == CAX_DRV_HIZ
		&& dminus_drive_sel == CAX_DRV_HIZ) else $error("plug-in");
	req_gate_a: assert property ($rose(pulse_voltage_up_req)
		|| $rose(pulse_voltage_down_req) |-> $past(pulse_ctrl_enable)) else $error("gate");
	seq_clear_a: assert property (pulse_seq_done && !reg_wr |=>
		!pulse_voltage_up_req && !pulse_voltage_down_req) else $error("seq clear");
	trim_write_a: assert property (reg_wr && reg_addr == ADDR_TRIM_IND
		&& !reg_reset_cmd && !watchdog_expired |=> charge_voltage_trim
		== $past(reg_wdata[7:6]) && trickle_current_sel == $past(reg_wdata[4]))
		else $error("trim write");
	led_mode_a: assert property ((charge_monitor_mode != MON_MODE_IND)[*3]
		|-> !stat_led_low) else $error("led mode");
endmodule
bind cax_regs cax_regs_asserts chk_u (.*);
`default_nettype wire

// File: test/cax_host_model.sv
// Host model: register reads and writes.
// Strobes one cycle, changed just after clk rises.
`timescale 1ns/1ns
`default_nettype none
module cax_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [3:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		{reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk);
		#10;
		reg_wr = 1'b0;
		// Stale data inverted so it never looks valid
		reg_wdata = ~v;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#10;
		reg_rd = 1'b0;
		v = reg_rdata;
	endtask
endmodule
`default_nettype wire

// File: test/cax_regs_tb_top.sv
// Testbench for the register slice.
// Host model drives the port; events come from here.
`timescale 1ns/1ns
`default_nettype none
module cax_regs_tb_top
	import cax_pkg::*;
;
	logic clk, nrst, reg_wr, reg_rd, reg_hit, reg_reset_cmd, watchdog_expired;
	logic safety_timer_restart, source_plugged, detection_done, pulse_seq_done;
	logic pulse_ctrl_enable, pulse_voltage_up_req, pulse_voltage_down_req;
	logic temp_profile_enable, trickle_current_sel, stat_led_low;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [1:0] charge_monitor_mode, charge_voltage_trim, input_reg_offset_sel;
	cax_drive_t dplus_drive_sel, dminus_drive_sel;
	int err_total = 0, tests_run = 0, n, cnt;
	cax_host_model host_u (.*);
	cax_regs #(.STEP_CYC(10)) dut_u (.*);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		host_u.rd(a, d);
		chk(d, e);
	endtask
	task automatic ev(ref logic s);
		@(posedge clk);
		#10;
		s = 1'b1;
		@(posedge clk);
		#10;
		s = 1'b0;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Whole run is a few hundred cycles
	initial begin
		#500000;
		err_total++;
		stop_test;
	end
	initial begin
		nrst = 1'b0;
		{reg_reset_cmd, watchdog_expired, source_plugged, detection_done, pulse_seq_done} = '0;
		charge_monitor_mode = 2'h0;
		repeat (16) @(posedge clk);
		#10;
		nrst = 1'b1;
		rdc(ADDR_PULSE_LINE, RST_PULSE_LINE);
		chk({pulse_ctrl_enable, temp_profile_enable}, 8'h01);
		rdc(ADDR_TRIM_IND, RST_TRIM_IND);
		rdc(ADDR_DET_STATE, 8'h00);
		rdc(4'h0, 8'h00);
		chk(reg_hit, 8'h00);
		host_u.wr(ADDR_PULSE_LINE, 8'hff);
		chk(pulse_ctrl_enable, 8'h01);
		rdc(ADDR_PULSE_LINE, 8'h81);
		ev(detection_done);
		rdc(ADDR_DET_STATE, 8'h80);
		for (n = 0; n < 4; n++) begin
			host_u.wr(ADDR_PULSE_LINE, 8'(8'h81 | n << 3 | (3 - n) << 1));
			chk(dplus_drive_sel, 8'(n));
			chk(dminus_drive_sel, 8'(3 - n));
		end
		host_u.wr(ADDR_PULSE_LINE, 8'hff);
		chk({pulse_voltage_up_req, pulse_voltage_down_req}, 8'h03);
		ev(pulse_seq_done);
		rdc(ADDR_PULSE_LINE, 8'h9f);
		ev(source_plugged);
		rdc(ADDR_PULSE_LINE, 8'h81);
		host_u.wr(ADDR_DET_STATE, 8'hff);
		rdc(ADDR_DET_STATE, 8'h00);
		chk(reg_hit, 8'h01);
		$display("done: pulse and line drive");
		host_u.wr(ADDR_TRIM_IND, 8'hff);
		rdc(ADDR_TRIM_IND, 8'hff);
		chk({charge_voltage_trim, trickle_current_sel, input_reg_offset_sel}, 8'h1f);
		// Clear the temperature enable so the watchdog has to restore it
		host_u.wr(ADDR_PULSE_LINE, 8'h00);
		chk(temp_profile_enable, 8'h00);
		ev(watchdog_expired);
		chk(temp_profile_enable, 8'h01);
		rdc(ADDR_TRIM_IND, 8'h03);
		rdc(ADDR_PULSE_LINE, RST_PULSE_LINE);
		ev(reg_reset_cmd);
		rdc(ADDR_TRIM_IND, 8'h00);
		$display("done: reset sources");
		host_u.wr(ADDR_TRIM_IND, 8'h04);
		charge_monitor_mode = MON_MODE_IND;
		repeat (3) @(posedge clk);
		#10;
		chk(stat_led_low, 8'h01);
		charge_monitor_mode = 2'h2;
		repeat (3) @(posedge clk);
		#10;
		chk(stat_led_low, 8'h00);
		for (n = 2; n < 4; n++) begin
			host_u.wr(ADDR_TRIM_IND, 8'(n << 2));
			charge_monitor_mode = MON_MODE_IND;
			repeat (4) @(posedge clk);
			cnt = 0;
			repeat (80) begin
				@(posedge clk);
				#10;
				cnt += stat_led_low;
			end
			chk(8'(cnt), n == 2 ? 8'h28 : 8'h14);
			charge_monitor_mode = 2'h0;
		end
		$display("done: indicator");
		stop_test;
	end
endmodule
`default_nettype wire
